/* bench/dtc_disk_transfer_controller_tb.sv */
`timescale 1ns/1ps
module dtc_disk_transfer_controller_tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [7:0] intVector;
    dtc_pkg::dtc_drive_in_t drvIn;
    dtc_pkg::dtc_drive_out_t drvOut;
    dtc_pkg::dtc_dma_in_t dmaIn;
    dtc_pkg::dtc_dma_out_t dmaOut;
    logic [15:0] hdrBase = 16'h0;
    logic [5:0] knob = 6'h0;
    logic [3:0] dly = 4'h0;
    logic [31:0] seed = 32'h771AC22E;
    logic [31:0] rd;
    logic se;
    logic [15:0] ba;
    logic [15:0] da;
    int polls;
    int mismatches = 0;
    int n_checks = 0;
    // fault table: function, knobs, expected error code
    int fFn [8] = '{6, 6, 6, 5, 5, 6, 5, 7};
    int fKn [8] = '{1, 2, 4, 4, 12, 8, 16, 32};
    int fErr [8] = '{3, 2, 4, 4, 8, 5, 9, 1};

    always #20 clock = ~clock;

    // timer must outlast a two-sector transfer (about 2100 cycles) in this model
    dtc_disk_transfer_controller #(.OPI_CYC(3000), .FIFO_DEPTH(256)) dut (.clock(clock),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .drvIn(drvIn),
        .drvOut(drvOut), .dmaIn(dmaIn), .dmaOut(dmaOut), .irq(irq), .intVector(intVector));

    dtc_drive_model drv (.clock(clock), .rst_n(rst_n), .drvOut(drvOut), .dmaOut(dmaOut),
        .hdrBase(hdrBase), .knob(knob), .dly(dly), .drvIn(drvIn), .dmaIn(dmaIn));

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : rnd

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            mismatches++;
            conclude();
        end
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdreg(input logic [7:0] a, input string what, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask : rdreg

    // load registers, start, poll ready; rd keeps the final status word
    task automatic op(input int n, input logic [2:0] fn, input logic ie, input int kn);
        ba = rnd();
        da = rnd() & 16'hFFDF; // sector field stays low so two sectors fit
        dly <= 4'(rnd() % 4);
        knob <= 6'(kn);
        hdrBase <= kn[3] ? da ^ 16'h8000 : da;
        drv.wrN = 0;
        apb(1'b1, dtc_pkg::OFS_BA, {16'h0, ba});
        apb(1'b1, dtc_pkg::OFS_BAE, 32'h1);
        apb(1'b1, dtc_pkg::OFS_DA, {16'h0, da});
        apb(1'b1, dtc_pkg::OFS_MP, {16'h0, 16'(-n)});
        apb(1'b1, dtc_pkg::OFS_CSR, {24'h0, 1'b0, ie, 2'b0, fn, 1'b0});
        for (polls = 0; polls < 4000; polls++) begin
            apb(1'b0, dtc_pkg::OFS_CSR, 32'h0);
            if (rd[7] === 1'b1) break;
        end
        if (polls == 4000) begin
            mismatches++;
            conclude();
        end
    endtask : op

    initial begin
        int e;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rdreg(dtc_pkg::OFS_CSR, "csr after init", 32'h80);
        check("vector", 32'(intVector), 32'h70);
        check("irq after init", 32'(irq), 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped error", 32'(se), 32'h1);
        check("unmapped data", rd, 32'h0);
        // seek comes back ready at once
        op(1, dtc_pkg::FN_SEEK, 1'b1, 0);
        check("seek polls", polls, 32'h0);
        check("seek strobes", drv.seeks, 32'h1);
        check("seek irq", 32'(irq), 32'h1);
        apb(1'b1, dtc_pkg::OFS_CSR, 32'h80);
        repeat (2) @(posedge clock);
        check("irq enable cleared", 32'(irq), 32'h0);
        // short write with a bad data crc, which a write must not report
        op(3, dtc_pkg::FN_WRITE, 1'b1, 2);
        check("write status", 32'(rd[15:10]), 32'h0);
        check("write irq", 32'(irq), 32'h1);
        rdreg(dtc_pkg::OFS_BA, "write address", 32'(16'(ba + 3)));
        rdreg(dtc_pkg::OFS_MP, "write count", 32'h0);
        rdreg(dtc_pkg::OFS_DA, "write disk address", 32'(16'(da + 1)));
        check("write word 0", 32'(drv.wrW[0]), 32'(ba ^ 16'h5A5A));
        check("write word 2", 32'(drv.wrW[2]), 32'(16'(ba + 2) ^ 16'h5A5A));
        check("write pad 3", 32'(drv.wrW[3]), 32'h0);
        check("write pad 127", 32'(drv.wrW[127]), 32'h0);
        // read over two sectors, interrupt disabled
        op(130, dtc_pkg::FN_READ, 1'b0, 0);
        check("read status", 32'(rd[15:10]), 32'h0);
        check("read irq", 32'(irq), 32'h0);
        rdreg(dtc_pkg::OFS_BA, "read address", 32'(16'(ba + 130)));
        rdreg(dtc_pkg::OFS_MP, "read count", 32'h0);
        rdreg(dtc_pkg::OFS_DA, "read disk address", 32'(16'(da + 2)));
        check("read first", 32'(drv.memW[ba[7:0]]), 32'hA000);
        check("read last", 32'(drv.memW[8'(ba + 129)]), 32'hA001);
        // headerless read against headers that never match
        // host issues it straight after setup, well inside the window
        op(130, dtc_pkg::FN_READNH, 1'b0, 8);
        check("headerless status", 32'(rd[15:10]), 32'h0);
        rdreg(dtc_pkg::OFS_DA, "headerless disk address", 32'(da));
        check("headerless last", 32'(drv.memW[8'(ba + 129)]), 32'hA001);
        // every fault kind ends the function with its code
        for (e = 0; e < 8; e++) begin
            op(4, 3'(fFn[e]), 1'b1, fKn[e]);
            check("error code", 32'(rd[13:10]), 32'(fErr[e]));
            check("any error", 32'(rd[15]), 32'h1);
            check("error irq", 32'(irq), 32'h1);
        end
        conclude();
    end
endmodule : dtc_disk_transfer_controller_tb

/* bench/dtc_drive_model.sv */
`timescale 1ns/1ps
// drive and memory stand-in; a word every 8 cycles lets one hold word keep up
module dtc_drive_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire dtc_pkg::dtc_drive_out_t drvOut,
    input wire dtc_pkg::dtc_dma_out_t dmaOut,
    input wire logic [15:0] hdrBase,
    input wire logic [5:0] knob,
    input wire logic [3:0] dly,
    output dtc_pkg::dtc_drive_in_t drvIn,
    output dtc_pkg::dtc_dma_in_t dmaIn
);
    logic [15:0] memW [0:255];
    logic [15:0] wrW [0:255];
    logic [1:0] cap = 2'b00;
    int wrN = 0;
    int seeks = 0;
    int cnt = 0;
    // next value of the drive lines; only idle() puts it on drvIn, once per edge
    dtc_pkg::dtc_drive_in_t pend = '0;

    // drop pulses; idle data lines toggle so a stale word never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clock);
            drvIn <= pend;
            pend = {2'b0, ~pend.hdrWord, 2'b0, ~pend.rdWord, 3'b0};
        end
    endtask : idle

    // one sector: mark, header, 128 word slots, end with data crc result
    initial begin
        int sec;
        int k;
        drvIn = '0;
        sec = 0;
        forever begin
            idle(1);
            if (!drvOut.active || knob[5]) begin
                sec = 0; // knob 5 keeps the spindle silent
            end else begin
                pend.sectorPulse = 1'b1;
                idle(4);
                pend.hdrValid = 1'b1;
                pend.hdrWord = hdrBase + 16'(sec);
                pend.hdrCrcOk = !knob[0];
                idle(4);
                for (k = 0; k < 128 && drvOut.active; k++) begin
                    pend.wordReq = drvOut.func == dtc_pkg::FN_WRITE;
                    pend.rdValid = drvOut.func != dtc_pkg::FN_WRITE;
                    pend.rdWord = 16'hA000 + 16'(k);
                    idle(8);
                end
                pend.sectorEnd = drvOut.active;
                pend.dataCrcOk = !knob[1];
                sec++;
                idle(4);
            end
        end
    end

    // memory answers after dly cycles; written words captured two cycles late
    always @(posedge clock) begin
        cap <= {cap[0], drvIn.wordReq};
        if (drvOut.seekStrobe) seeks++;
        if (cap[1]) begin
            wrW[wrN & 255] <= drvOut.wrWord;
            wrN++;
        end
        if (!dmaOut.req || knob[2] || dmaIn.ack) begin
            cnt <= 0;
            dmaIn <= {1'b0, ~dmaIn.rdata, 1'b0};
        end else if (cnt < dly) begin
            cnt <= cnt + 1;
            dmaIn <= {1'b0, ~dmaIn.rdata, 1'b0};
        end else begin
            cnt <= 0;
            dmaIn <= {1'b1, dmaOut.addr[15:0] ^ 16'h5A5A, knob[4]};
            if (dmaOut.write) memW[dmaOut.addr[7:0]] <= dmaOut.wdata;
        end
    end
endmodule : dtc_drive_model

/* hdl/dtc_disk_transfer_controller.sv */
// How it works
// - write: match headers to disk address, good header crc, then write sector
// - each moved word increments bus address and word count
// - write pads sector with zeros; sector field advances; continue while words remain
// - write end sets ready; interrupt only if enable set
// - read: match header, check header crc, read to memory until count zero
// - read checks data crc, advances disk address, next sector unless count done
// - headerless read takes data after next sector pulse, checks only data crc
// - headerless read leaves disk address unchanged
// - operation timer expiry sets bit 10 alone
// - data crc error on read sets bit 11 alone; never on write
// - header crc error sets bits 11 and 10
// - data late sets bit 12 alone: write underrun, read overrun
// - header not found before timer sets bits 12 and 10
// - dma unanswered within 10 us sets bit 13 alone
// - parity error on dma read sets bits 13 and 10
// - interrupt requested while enable and ready both set, vector 160
// - software writes enable; init sets ready; clearing ready starts a function
// - seek completes immediately with ready; interrupt only if enable set
// - sector starts only when buffer has room for a whole sector
// - operation timer starts when ready is cleared
`timescale 1ns/1ps
module dtc_disk_transfer_controller #(
    parameter int OPI_CYC = dtc_pkg::OPI_CYCLES,
    parameter int FIFO_DEPTH = dtc_pkg::FIFO_WORDS
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dtc_pkg::dtc_drive_in_t drvIn,
    output dtc_pkg::dtc_drive_out_t drvOut,
    input wire dtc_pkg::dtc_dma_in_t dmaIn,
    output dtc_pkg::dtc_dma_out_t dmaOut,
    output logic irq,
    output logic [7:0] intVector
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HDR = 5'b00010,
        ST_PULSE = 5'b00100,
        ST_DATA = 5'b01000,
        ST_END = 5'b10000
    } dtc_state_t;

    localparam logic [31:0] OPI_LIM = 32'(OPI_CYC);
    localparam logic [15:0] NXM_LIM = 16'(dtc_pkg::NXM_CYCLES);

    dtc_state_t state, next_state;
    logic [2:0] func, next_func;
    logic ie, next_ie;
    logic controller_ready_flag, next_controller_ready_flag;
    logic [3:0] err, next_err;
    logic [15:0] ba, next_ba;
    logic [1:0] bae, next_bae;
    logic [15:0] da, next_da;
    logic [15:0] mp, next_mp;
    logic [15:0] hold, next_hold;
    logic holdFull, next_holdFull;
    logic [31:0] opiCnt, next_opiCnt;
    logic [15:0] dmaWait, next_dmaWait;
    dtc_pkg::dtc_drive_out_t next_drvOut;
    dtc_pkg::dtc_dma_out_t next_dmaOut;
    logic next_irq;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;

    logic [15:0] csrView;
    logic wrAccess, isWrite, wantMore, roomOk;

    // apb: data registered in setup phase, so access completes with no wait state
    assign wrAccess = psel && penable && pready && pwrite;
    assign csrView = {(err != dtc_pkg::ERR_NONE), 1'b0, err, 2'b00, controller_ready_flag, ie, 2'b00, func, 1'b0};
    assign isWrite = (func == dtc_pkg::FN_WRITE);
    // one extra pending word in hold counts against the remaining count
    assign wantMore = (mp != 16'h0000) && !(holdFull && mp == 16'hFFFF);
    // hold occupancy is 0 or 1 word; compare against a full sector of space
    assign roomOk = (FIFO_DEPTH - int'(holdFull)) >= dtc_pkg::SECTOR_WORDS;

    // apb response
    always_comb begin
        next_pready = psel && !penable;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        if (psel && !penable) begin
            unique case (paddr)
                dtc_pkg::OFS_CSR: next_prdata = {16'h0000, csrView};
                dtc_pkg::OFS_BA: next_prdata = {16'h0000, ba};
                dtc_pkg::OFS_DA: next_prdata = {16'h0000, da};
                dtc_pkg::OFS_MP: next_prdata = {16'h0000, mp};
                dtc_pkg::OFS_BAE: next_prdata = {30'h0000_0000, bae};
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // command engine
    always_comb begin
        next_state = state;
        next_func = func;
        next_ie = ie;
        next_controller_ready_flag = controller_ready_flag;
        next_err = err;
        next_ba = ba;
        next_bae = bae;
        next_da = da;
        next_mp = mp;
        next_hold = hold;
        next_holdFull = holdFull;
        next_opiCnt = opiCnt;
        next_dmaWait = dmaWait;
        next_drvOut = drvOut;
        next_drvOut.seekStrobe = 1'b0;
        next_dmaOut = dmaOut;

        if (!controller_ready_flag) begin
            next_opiCnt = opiCnt + 32'h0000_0001;
        end

        if (dmaOut.req) begin
            next_dmaWait = dmaWait + 16'h0001;
            if (dmaIn.ack) begin
                next_dmaOut.req = 1'b0;
                next_dmaWait = 16'h0000;
                {next_bae, next_ba} = {bae, ba} + 18'h00001;
                next_mp = mp + 16'h0001;
                next_holdFull = !holdFull;
                if (!dmaOut.write) begin
                    next_hold = dmaIn.rdata;
                end
            end
        end else if (state == ST_DATA || state == ST_END || state == ST_HDR) begin
            if (isWrite && !holdFull && mp != 16'h0000) begin
                next_dmaOut.req = 1'b1;
                next_dmaOut.write = 1'b0;
                next_dmaOut.addr = {bae, ba};
            end else if (!isWrite && holdFull) begin
                next_dmaOut.req = 1'b1;
                next_dmaOut.write = 1'b1;
                next_dmaOut.addr = {bae, ba};
                next_dmaOut.wdata = hold;
            end
        end

        unique case (state)
            ST_IDLE: begin
                // ready cleared by software starts the function
                if (wrAccess && paddr == dtc_pkg::OFS_CSR && controller_ready_flag && !pwdata[dtc_pkg::CSR_RDY]) begin
                    next_func = pwdata[dtc_pkg::CSR_FN_LO +: 3];
                    next_err = dtc_pkg::ERR_NONE;
                    next_opiCnt = 32'h0000_0000;
                    next_holdFull = 1'b0;
                    next_drvOut.func = pwdata[dtc_pkg::CSR_FN_LO +: 3];
                    unique case (pwdata[dtc_pkg::CSR_FN_LO +: 3])
                        dtc_pkg::FN_WRITE, dtc_pkg::FN_READ: begin
                            next_controller_ready_flag = 1'b0;
                            next_state = ST_HDR;
                            next_drvOut.active = 1'b1;
                        end
                        dtc_pkg::FN_READNH: begin
                            next_controller_ready_flag = 1'b0;
                            next_state = ST_PULSE;
                            next_drvOut.active = 1'b1;
                        end
                        // seek is done as soon as it is issued
                        dtc_pkg::FN_SEEK: begin
                            next_drvOut.seekStrobe = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            ST_HDR: begin
                if (drvIn.hdrValid && drvIn.hdrWord == da && roomOk) begin
                    if (drvIn.hdrCrcOk) begin
                        next_state = ST_DATA;
                    end else begin
                        next_err = dtc_pkg::ERR_HEADER_CRC_ERROR;
                    end
                end
            end
            ST_PULSE: begin
                // a sector begins only with room for all of it
                if (drvIn.sectorPulse && roomOk) begin
                    next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (isWrite && drvIn.wordReq) begin
                    // zero fill after the last memory word
                    if (holdFull) begin
                        next_drvOut.wrWord = hold;
                        next_holdFull = 1'b0;
                    end else if (mp == 16'h0000) begin
                        next_drvOut.wrWord = 16'h0000;
                    end else begin
                        next_err = dtc_pkg::ERR_DLT;
                    end
                end else if (!isWrite && drvIn.rdValid && wantMore) begin
                    if (holdFull) begin
                        next_err = dtc_pkg::ERR_DLT;
                    end else begin
                        next_hold = drvIn.rdWord;
                        next_holdFull = 1'b1;
                    end
                end
                if (drvIn.sectorEnd) begin
                    next_state = ST_END;
                    // data crc counts only on reads
                    if (!isWrite && !drvIn.dataCrcOk) begin
                        next_err = dtc_pkg::ERR_DATA_CRC_ERROR;
                    end
                    // sector advance, not for headerless read
                    if (func != dtc_pkg::FN_READNH) begin
                        next_da[dtc_pkg::SECTOR_MSB:0] = da[dtc_pkg::SECTOR_MSB:0] + 6'h01;
                    end
                end
            end
            ST_END: begin
                // reads drain the last word to memory before deciding
                if (isWrite || !holdFull) begin
                    if (mp == 16'h0000 && !holdFull) begin
                        next_controller_ready_flag = 1'b1;
                        next_state = ST_IDLE;
                        next_drvOut.active = 1'b0;
                    end else if (func == dtc_pkg::FN_READNH) begin
                        next_state = ST_PULSE;
                    end else begin
                        next_state = ST_HDR;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase

        if (dmaOut.req && !dmaIn.ack && dmaWait >= NXM_LIM - 16'h0001) begin
            next_err = dtc_pkg::ERR_NXM;
        end
        // parity error on data into the controller
        if (dmaOut.req && dmaIn.ack && !dmaOut.write && dmaIn.parityErr) begin
            next_err = dtc_pkg::ERR_MPE;
        end
        if (!controller_ready_flag && opiCnt >= OPI_LIM - 32'h0000_0001) begin
            next_err = (state == ST_HDR) ? dtc_pkg::ERR_HNF : dtc_pkg::ERR_OPI;
        end
        // any new error ends the function
        if (!controller_ready_flag && next_err != dtc_pkg::ERR_NONE) begin
            next_controller_ready_flag = 1'b1;
            next_state = ST_IDLE;
            next_drvOut.active = 1'b0;
            next_dmaOut.req = 1'b0;
            next_dmaWait = 16'h0000;
        end

        // register writes from software; the engine owns counters while busy
        if (wrAccess) begin
            unique case (paddr)
                dtc_pkg::OFS_CSR: next_ie = pwdata[dtc_pkg::CSR_IE];
                dtc_pkg::OFS_BA: if (controller_ready_flag) next_ba = pwdata[15:0];
                dtc_pkg::OFS_DA: if (controller_ready_flag) next_da = pwdata[15:0];
                dtc_pkg::OFS_MP: if (controller_ready_flag) next_mp = pwdata[15:0];
                dtc_pkg::OFS_BAE: if (controller_ready_flag) next_bae = pwdata[1:0];
                default: ;
            endcase
        end

        // interrupt request while enabled and ready
        next_irq = next_ie && next_controller_ready_flag;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            func <= 3'h0;
            ie <= 1'b0;
            controller_ready_flag <= 1'b1;
            err <= dtc_pkg::ERR_NONE;
            ba <= 16'h0000;
            bae <= 2'h0;
            da <= 16'h0000;
            mp <= 16'h0000;
            hold <= 16'h0000;
            holdFull <= 1'b0;
            opiCnt <= 32'h0000_0000;
            dmaWait <= 16'h0000;
            drvOut <= '0;
            dmaOut <= '0;
            irq <= 1'b0;
            intVector <= 8'h00;
        end else begin
            state <= next_state;
            func <= next_func;
            ie <= next_ie;
            controller_ready_flag <= next_controller_ready_flag;
            err <= next_err;
            ba <= next_ba;
            bae <= next_bae;
            da <= next_da;
            mp <= next_mp;
            hold <= next_hold;
            holdFull <= next_holdFull;
            opiCnt <= next_opiCnt;
            dmaWait <= next_dmaWait;
            drvOut <= next_drvOut;
            dmaOut <= next_dmaOut;
            irq <= next_irq;
            intVector <= dtc_pkg::INT_VECTOR;
        end
    end

    // checks
    a_irq_tracks_ready: assert property (@(posedge clock) disable iff (!rst_n)
        irq == $past(next_ie && next_controller_ready_flag)) else $error("irq not ie and ready");
    a_seek_ready_now: assert property (@(posedge clock) disable iff (!rst_n)
        drvOut.seekStrobe |-> controller_ready_flag && state == ST_IDLE) else $error("seek left busy");
    a_start_clears_ready: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(drvOut.active) |-> !controller_ready_flag && opiCnt == 32'h0000_0000) else $error("start bad");
    a_error_ends_fn: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(err) && err != dtc_pkg::ERR_NONE |-> controller_ready_flag && state == ST_IDLE)
        else $error("error did not end function");
    a_dma_counts_word: assert property (@(posedge clock) disable iff (!rst_n)
        dmaOut.req && dmaIn.ack && err == dtc_pkg::ERR_NONE |=> mp == $past(mp) + 16'h0001)
        else $error("word count not stepped");
    a_nohdr_keeps_da: assert property (@(posedge clock) disable iff (!rst_n)
        func == dtc_pkg::FN_READNH && !controller_ready_flag |=> $stable(da)) else $error("da moved");
    a_write_no_data_crc_error: assert property (@(posedge clock) disable iff (!rst_n)
        isWrite |-> err != dtc_pkg::ERR_DATA_CRC_ERROR) else $error("data_crc_error on write");
    a_nxm_bound: assert property (@(posedge clock) disable iff (!rst_n)
        dmaWait < NXM_LIM) else $error("dma wait beyond limit");
    a_opi_bound: assert property (@(posedge clock) disable iff (!rst_n)
        opiCnt <= OPI_LIM) else $error("operation timer overran");
    c_write_done: cover property (@(posedge clock) disable iff (!rst_n)
        isWrite && $rose(controller_ready_flag) && err == dtc_pkg::ERR_NONE);
    c_read_done: cover property (@(posedge clock) disable iff (!rst_n)
        func == dtc_pkg::FN_READ && $rose(controller_ready_flag) && err == dtc_pkg::ERR_NONE);
    c_hnf: cover property (@(posedge clock) disable iff (!rst_n) err == dtc_pkg::ERR_HNF);
    c_seek: cover property (@(posedge clock) disable iff (!rst_n) drvOut.seekStrobe && irq);
endmodule : dtc_disk_transfer_controller

/* hdl/dtc_pkg.sv */
package dtc_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFS_CSR = 8'h00;
    localparam logic [7:0] OFS_BA = 8'h04;
    localparam logic [7:0] OFS_DA = 8'h08;
    localparam logic [7:0] OFS_MP = 8'h0C;
    localparam logic [7:0] OFS_BAE = 8'h10;
    // control_status_reg field positions
    localparam int CSR_FN_LO = 1;
    localparam int CSR_IE = 6;
    localparam int CSR_RDY = 7;
    localparam int CSR_ERR_LO = 10;
    localparam int CSR_ANYERR = 15;
    // function codes
    localparam logic [2:0] FN_SEEK = 3'h3;
    localparam logic [2:0] FN_WRITE = 3'h5;
    localparam logic [2:0] FN_READ = 3'h6;
    localparam logic [2:0] FN_READNH = 3'h7;
    // error codes for csr bits 13:10
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_OPI = 4'h1;
    localparam logic [3:0] ERR_DATA_CRC_ERROR = 4'h2;
    localparam logic [3:0] ERR_HEADER_CRC_ERROR = 4'h3;
    localparam logic [3:0] ERR_DLT = 4'h4;
    localparam logic [3:0] ERR_HNF = 4'h5;
    localparam logic [3:0] ERR_NXM = 4'h8;
    localparam logic [3:0] ERR_MPE = 4'h9;
    // geometry and buffer
    localparam int SECTOR_WORDS = 128;
    localparam int FIFO_WORDS = 256;
    localparam int SECTOR_MSB = 5;
    localparam logic [7:0] INT_VECTOR = 8'h70; // 160 octal
    // timing
    localparam int CLK_HZ = 25000000;
    localparam int OPI_MS = 200;
    localparam int OPI_CYCLES = OPI_MS * (CLK_HZ / 1000);
    localparam int NXM_US = 10;
    localparam int NXM_CYCLES = NXM_US * (CLK_HZ / 1000000);
    localparam logic [15:0] RST_CSR = 16'h0080;

    typedef struct packed {
        logic sectorPulse;
        logic hdrValid;
        logic [15:0] hdrWord;
        logic hdrCrcOk;
        logic rdValid;
        logic [15:0] rdWord;
        logic wordReq;
        logic sectorEnd;
        logic dataCrcOk;
    } dtc_drive_in_t;

    typedef struct packed {
        logic [2:0] func;
        logic active;
        logic seekStrobe;
        logic [15:0] wrWord;
    } dtc_drive_out_t;

    typedef struct packed {
        logic req;
        logic write;
        logic [17:0] addr;
        logic [15:0] wdata;
    } dtc_dma_out_t;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
        logic parityErr;
    } dtc_dma_in_t;
endpackage : dtc_pkg
